// *** hw/qrr_pkg.sv ***
// Shared constants and types for the query register responder
package qrr_pkg;

  // ==========================================================================
  // Query register addresses
  localparam logic [7:0] ADDR_PARAM   = 8'h30;
  localparam logic [7:0] ADDR_TEMP    = 8'h31;
  localparam logic [7:0] ADDR_COND    = 8'h32;
  localparam logic [7:0] ADDR_INFO    = 8'h33;
  localparam logic [7:0] ADDR_CALMEM  = 8'h34;
  localparam logic [7:0] ADDR_USERMEM = 8'h35;
  localparam logic [7:0] ADDR_CLKOUT  = 8'h36;

  // ==========================================================================
  // Data bytes that follow each address byte
  localparam logic [2:0] LEN_SHORT  = 3'h1;
  localparam logic [2:0] LEN_MEM    = 3'h3;
  localparam logic [2:0] LEN_CLKOUT = 3'h7;

  // ==========================================================================
  // Selector codes
  localparam logic [3:0] PSEL_RF     = 4'h0;
  localparam logic [3:0] PSEL_IF     = 4'h1;
  localparam logic [3:0] PSEL_LO     = 4'h2;
  localparam logic [3:0] PSEL_OTHER  = 4'h3;
  localparam logic [3:0] ISEL_SERIAL = 4'h0;
  localparam logic [3:0] ISEL_REV    = 4'h1;
  localparam logic [3:0] ISEL_DATE   = 4'h2;

  // ==========================================================================
  // Response layout
  localparam int         RESP_W    = 64;
  localparam int         FREQ_W    = 56;
  localparam int         NV_ADDR_W = 16;
  localparam logic [2:0] LAST_BYTE = 3'h7;

  // Signal-path byte of the other-settings answer
  localparam int SP_BYPASS  = 0;
  localparam int SP_AMP     = 1;
  localparam int SP_IFOUT   = 2;
  localparam int SP_INV_LSB = 3;

  // Condition word bit positions
  localparam int CB_LOCK_LSB  = 0;
  localparam int CB_REF_LOCK  = 4;
  localparam int CB_GAIN_LSB  = 5;
  localparam int CB_ACCESSED  = 8;
  localparam int CB_EXTREF    = 9;
  localparam int CB_EXTLOCK   = 10;
  localparam int CB_OSC_PWR   = 11;
  localparam int CB_EXT_OSC   = 12;
  localparam int CB_PORT_REAR = 13;
  localparam int CB_DIRECT    = 14;
  localparam int CB_DOUBLER   = 15;
  localparam int CB_STANDBY   = 16;
  localparam int CB_BYPASS    = 17;
  localparam int CB_IFOUT     = 18;
  localparam int CB_INVERT    = 19;
  localparam int CB_PREAMP    = 20;
  localparam int CB_AUTO_GAIN = 21;
  localparam int CB_AUTO_AMP  = 22;

  // Interface map byte position within the serial-number answer
  localparam int INFO_MAP_LSB = 32;

  // ==========================================================================
  // Command parser states
  typedef enum logic [4:0] {
    QRR_ADDR = 5'b00001,
    QRR_DATA = 5'b00010,
    QRR_SKIP = 5'b00100,
    QRR_MEM  = 5'b01000,
    QRR_LOAD = 5'b10000
  } qrr_state_t;

endpackage

// *** hw/qrr_nv_window.sv ***
// Byte-wide non-volatile store with an eight-byte read window
module qrr_nv_window (
  input  wire logic                            clk,
  input  wire logic                            reset_n,
  input  wire logic                            wr_en,
  input  wire logic [qrr_pkg::NV_ADDR_W-1:0]   wr_addr,
  input  wire logic [7:0]                      wr_data,
  input  wire logic                            rd_start,
  input  wire logic [qrr_pkg::NV_ADDR_W-1:0]   rd_addr,
  output logic      [qrr_pkg::RESP_W-1:0]      rd_word,
  output logic                                 rd_done
);
  import qrr_pkg::*;

  logic [7:0]           mem [0:(1 << NV_ADDR_W)-1];
  logic                 busy;
  logic [2:0]           cnt;
  logic [NV_ADDR_W-1:0] base;
  logic [NV_ADDR_W-1:0] rd_ptr;

  // ==========================================================================
  // Storage, loaded from outside
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Addresses wrap inside the 16-bit space
  assign rd_ptr = base + {13'h0000, cnt};

  // ==========================================================================
  // Window read, one byte a cycle, start byte in the lowest lane
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy    <= 1'b0;
      cnt     <= 3'h0;
      base    <= '0;
      rd_word <= '0;
      rd_done <= 1'b0;
    end else begin
      rd_done <= 1'b0;
      if (rd_start && !busy) begin
        busy <= 1'b1;
        cnt  <= 3'h0;
        base <= rd_addr;
      end else if (busy) begin
        rd_word[cnt*8 +: 8] <= mem[rd_ptr];
        cnt                 <= cnt + 3'h1;
        if (cnt == LAST_BYTE) begin
          busy    <= 1'b0;
          rd_done <= 1'b1;
        end
      end
    end
  end

endmodule

// *** hw/qrr_responder.sv ***
// Query register command parser and eight-byte response engine
//
// Contract
// - Parameter query low nibble selects frequency/settings.
// - Temperature float in low word, upper zero.
// - Bits 0-4 report five loop locks, bit 4 only with external lock enabled.
// - Loop gain in 6:5, bit8 system accessed.
// - Bits 9-16 reference, oscillator, standby flags.
// - Bits 17-22 path flags, rest zero.
// - Info query low nibble selects, upper ignored.
// - Calibration read returns eight bytes, start lowest.
// - User memory read same form, user area.
// - Clock-out frame shifts eight response bytes.
// - Frequency in seven bytes, top byte zero.
// - Frequency unsigned, LSB one millihertz.
// - Other settings: attenuations, path, zeros.
// - Path bits: bypass, amp, IF out, inversion.
// - Serial number low four, interface map byte4.
// - Hardware revision low, firmware revision high.
// - Manufacture date low, calibration date high.
// - Frame is address byte, data MSB first.
// - Response eight bytes, MSB first, fully read.
// - Ready low while processing; input ignored.
module qrr_responder (
  input  wire logic                           clk,
  input  wire logic                           reset_n,
  input  wire logic [7:0]                     rx_data,
  input  wire logic                           rx_valid,
  input  wire logic                           frame_active,
  input  wire logic                           tx_take,
  input  wire logic [qrr_pkg::FREQ_W-1:0]     freq_rf,
  input  wire logic [qrr_pkg::FREQ_W-1:0]     freq_if,
  input  wire logic [qrr_pkg::FREQ_W-1:0]     freq_lo,
  input  wire logic [7:0]                     atten_if,
  input  wire logic [7:0]                     atten_rf,
  input  wire logic                           conversion_bypassed,
  input  wire logic                           preamplifier_on,
  input  wire logic                           intermediate_output_on,
  input  wire logic                           spectrum_inverted,
  input  wire logic [31:0]                    temperature,
  input  wire logic [4:0]                     loop_lock,
  input  wire logic [1:0]                     loop_gain,
  input  wire logic                           system_accessed,
  input  wire logic                           external_reference_present,
  input  wire logic                           external_reference_lock_enabled,
  input  wire logic                           oscillator_power_on,
  input  wire logic                           external_oscillator_selected,
  input  wire logic                           oscillator_port_rear,
  input  wire logic                           oscillator_direct_entry,
  input  wire logic                           oscillator_doubler_on,
  input  wire logic                           standby_asserted,
  input  wire logic                           automatic_gain_selected,
  input  wire logic                           automatic_amplifier_selected,
  input  wire logic [31:0]                    serial_number,
  input  wire logic [3:0]                     interface_map,
  input  wire logic [31:0]                    hw_revision,
  input  wire logic [31:0]                    fw_revision,
  input  wire logic [31:0]                    mfg_date,
  input  wire logic [31:0]                    cal_date,
  input  wire logic                           cal_wr_en,
  input  wire logic                           user_wr_en,
  input  wire logic [qrr_pkg::NV_ADDR_W-1:0]  nv_wr_addr,
  input  wire logic [7:0]                     nv_wr_data,
  output logic                                serial_ready_out,
  output logic      [7:0]                     tx_byte,
  output logic                                tx_pending,
  output logic      [qrr_pkg::RESP_W-1:0]     resp_word,
  output logic                                resp_valid
);
  import qrr_pkg::*;

  qrr_state_t         state;
  logic [7:0]         cmd_addr;
  logic [23:0]        cmd_data;
  logic [23:0]        next_cmd_data;
  logic [2:0]         remaining;
  logic               mem_start_cal;
  logic               mem_start_user;
  logic [RESP_W-1:0]  cal_word;
  logic [RESP_W-1:0]  user_word;
  logic               cal_done;
  logic               user_done;
  logic [RESP_W-1:0]  tx_shift;
  logic [2:0]         tx_idx;
  logic [RESP_W-1:0]  next_resp;
  logic [RESP_W-1:0]  cond_word;
  logic [7:0]         path_byte;
  logic               byte_in;
  logic               clkout_byte;
  logic               pop;

  // Data bytes arrive most significant first, so shift in from the bottom
  assign next_cmd_data = {cmd_data[15:0], rx_data};
  assign byte_in       = rx_valid && frame_active;

  // ==========================================================================
  // Command parser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state          <= QRR_ADDR;
      cmd_addr       <= 8'h00;
      cmd_data       <= 24'h000000;
      remaining      <= 3'h0;
      mem_start_cal  <= 1'b0;
      mem_start_user <= 1'b0;
    end else begin
      mem_start_cal  <= 1'b0;
      mem_start_user <= 1'b0;
      case (state)
        QRR_ADDR: begin
          if (byte_in) begin
            cmd_addr <= rx_data;
            cmd_data <= 24'h000000;
            case (rx_data)
              ADDR_PARAM, ADDR_TEMP, ADDR_COND, ADDR_INFO: begin
                remaining <= LEN_SHORT;
                state     <= QRR_DATA;
              end
              ADDR_CALMEM, ADDR_USERMEM: begin
                remaining <= LEN_MEM;
                state     <= QRR_DATA;
              end
              ADDR_CLKOUT: begin
                remaining <= LEN_CLKOUT;
                state     <= QRR_DATA;
              end
              default: begin
                // Configuration traffic belongs to another block
                state <= QRR_SKIP;
              end
            endcase
          end
        end
        QRR_DATA: begin
          // A frame cut short is dropped rather than hanging the parser
          if (!frame_active) begin
            state <= QRR_ADDR;
          end else if (rx_valid) begin
            cmd_data  <= next_cmd_data;
            remaining <= remaining - 3'h1;
            if (remaining == 3'h1) begin
              if (cmd_addr == ADDR_CLKOUT) begin
                state <= QRR_ADDR;
              end else if (cmd_addr == ADDR_CALMEM) begin
                mem_start_cal <= 1'b1;
                state         <= QRR_MEM;
              end else if (cmd_addr == ADDR_USERMEM) begin
                mem_start_user <= 1'b1;
                state          <= QRR_MEM;
              end else begin
                state <= QRR_LOAD;
              end
            end
          end
        end
        QRR_SKIP: begin
          // A foreign frame may carry bytes that look like query addresses
          if (!frame_active) begin
            state <= QRR_ADDR;
          end
        end
        QRR_MEM: begin
          // Input is not sampled here: the host sees ready low
          if (cal_done || user_done) begin
            state <= QRR_LOAD;
          end
        end
        QRR_LOAD: begin
          // The answer is registered this cycle, so ready rises with it
          state <= QRR_ADDR;
        end
        default: begin
          state <= QRR_ADDR;
        end
      endcase
    end
  end

  // ==========================================================================
  // Ready output: low from the last command byte of any query except clock-out until the answer is loaded
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_ready_out <= 1'b1;
    end else if (state == QRR_DATA && byte_in && remaining == 3'h1 &&
                 cmd_addr != ADDR_CLKOUT) begin
      serial_ready_out <= 1'b0;
    end else if (state == QRR_LOAD) begin
      serial_ready_out <= 1'b1;
    end
  end

  // ==========================================================================
  // Calibration and user memories
  // Separate stores, so a user write can never touch calibration data
  qrr_nv_window u_cal_mem (
    .clk      (clk),
    .reset_n  (reset_n),
    .wr_en    (cal_wr_en),
    .wr_addr  (nv_wr_addr),
    .wr_data  (nv_wr_data),
    .rd_start (mem_start_cal),
    .rd_addr  (cmd_data[15:0]),
    .rd_word  (cal_word),
    .rd_done  (cal_done)
  );

  qrr_nv_window u_user_mem (
    .clk      (clk),
    .reset_n  (reset_n),
    .wr_en    (user_wr_en),
    .wr_addr  (nv_wr_addr),
    .wr_data  (nv_wr_data),
    .rd_start (mem_start_user),
    .rd_addr  (cmd_data[15:0]),
    .rd_word  (user_word),
    .rd_done  (user_done)
  );

  // ==========================================================================
  // Answer fields
  always_comb begin
    path_byte                         = 8'h00;
    path_byte[SP_BYPASS]              = conversion_bypassed;
    path_byte[SP_AMP]                 = preamplifier_on;
    path_byte[SP_IFOUT]               = intermediate_output_on;
    path_byte[SP_INV_LSB +: 2]        = {1'b0, spectrum_inverted};
  end

  always_comb begin
    cond_word                         = '0;
    cond_word[CB_LOCK_LSB +: 4]       = loop_lock[3:0];
    // Reference loop lock means nothing unless external locking is on
    cond_word[CB_REF_LOCK]            = loop_lock[4] && external_reference_lock_enabled;
    cond_word[CB_GAIN_LSB +: 2]       = loop_gain;
    cond_word[CB_ACCESSED]            = system_accessed;
    cond_word[CB_EXTREF]              = external_reference_present;
    cond_word[CB_EXTLOCK]             = external_reference_lock_enabled;
    cond_word[CB_OSC_PWR]             = oscillator_power_on;
    cond_word[CB_EXT_OSC]             = external_oscillator_selected;
    cond_word[CB_PORT_REAR]           = oscillator_port_rear;
    cond_word[CB_DIRECT]              = oscillator_direct_entry;
    cond_word[CB_DOUBLER]             = oscillator_doubler_on;
    cond_word[CB_STANDBY]             = standby_asserted;
    cond_word[CB_BYPASS]              = conversion_bypassed;
    cond_word[CB_IFOUT]               = intermediate_output_on;
    cond_word[CB_INVERT]              = spectrum_inverted;
    cond_word[CB_PREAMP]              = preamplifier_on;
    cond_word[CB_AUTO_GAIN]           = automatic_gain_selected;
    cond_word[CB_AUTO_AMP]            = automatic_amplifier_selected;
  end

  // ==========================================================================
  // Response selection; unknown selectors answer all zeros
  always_comb begin
    next_resp = '0;
    case (cmd_addr)
      ADDR_PARAM: begin
        // Frequencies pass through as unsigned millihertz counts
        case (cmd_data[3:0])
          PSEL_RF:    next_resp = {8'h00, freq_rf};
          PSEL_IF:    next_resp = {8'h00, freq_if};
          PSEL_LO:    next_resp = {8'h00, freq_lo};
          PSEL_OTHER: next_resp = {40'h0000000000, path_byte, atten_rf, atten_if};
          default:    next_resp = '0;
        endcase
      end
      ADDR_TEMP: begin
        next_resp = {32'h00000000, temperature};
      end
      ADDR_COND: begin
        next_resp = cond_word;
      end
      ADDR_INFO: begin
        // Upper nibble of the selector is don't-care
        case (cmd_data[3:0])
          ISEL_SERIAL: begin
            next_resp                       = {32'h00000000, serial_number};
            next_resp[INFO_MAP_LSB +: 4]    = interface_map;
          end
          ISEL_REV:  next_resp = {fw_revision, hw_revision};
          ISEL_DATE: next_resp = {cal_date, mfg_date};
          default:   next_resp = '0;
        endcase
      end
      ADDR_CALMEM:  next_resp = cal_word;
      ADDR_USERMEM: next_resp = user_word;
      default:      next_resp = '0;
    endcase
  end

  // ==========================================================================
  // Whole answer word, flagged for one cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resp_word  <= '0;
      resp_valid <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      if (state == QRR_LOAD) begin
        resp_word  <= next_resp;
        resp_valid <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Byte stream out, most significant byte first
  // Every byte of a clock-out frame, its address byte included, moves one
  // answer byte, so the eight bytes leave over the frame's eight bytes.
  assign clkout_byte = byte_in &&
                       ((state == QRR_ADDR && rx_data == ADDR_CLKOUT) ||
                        (state == QRR_DATA && cmd_addr == ADDR_CLKOUT));
  assign pop         = (tx_take || clkout_byte) && tx_pending;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_shift   <= '0;
      tx_byte    <= 8'h00;
      tx_idx     <= 3'h0;
      tx_pending <= 1'b0;
    end else if (state == QRR_LOAD) begin
      // A new answer replaces anything not yet drained
      tx_shift   <= next_resp;
      tx_byte    <= next_resp[RESP_W-1 -: 8];
      tx_idx     <= 3'h0;
      tx_pending <= 1'b1;
    end else if (pop) begin
      tx_shift <= {tx_shift[RESP_W-9:0], 8'h00};
      tx_idx   <= tx_idx + 3'h1;
      if (tx_idx == LAST_BYTE) begin
        // Buffer counts as cleared only after all eight bytes went out
        tx_pending <= 1'b0;
        tx_byte    <= 8'h00;
      end else begin
        tx_byte <= tx_shift[RESP_W-9 -: 8];
      end
    end
  end

endmodule

// *** testbench/qrr_responder_assertions.sv ***
// Port-level assertions for the query responder
module qrr_responder_assertions (
  input wire logic                       clk,
  input wire logic                       reset_n,
  input wire logic                       rx_valid,
  input wire logic                       frame_active,
  input wire logic                       tx_take,
  input wire logic                       serial_ready_out,
  input wire logic [7:0]                 tx_byte,
  input wire logic                       tx_pending,
  input wire logic [qrr_pkg::RESP_W-1:0] resp_word,
  input wire logic                       resp_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import qrr_pkg::*;
  // ==========================================================
  // Pop tracking
  logic       pop;
  logic [3:0] cnt;
  logic [3:0] cur;
  logic [7:0] nxt;
  // Assumes an answer is drained before the next query starts
  assign pop = tx_pending && (tx_take || (rx_valid && frame_active && serial_ready_out));
  assign cur = resp_valid ? 4'h0 : cnt;
  assign nxt = (cur < 4'h7) ? 8'(resp_word >> (48 - 8 * int'(cur))) : 8'h00;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 4'h8;
    end else if (pop) begin
      cnt <= cur + 4'h1;
    end else if (resp_valid) begin
      cnt <= 4'h0;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_drop_cause;
    $fell(serial_ready_out) |-> $past(rx_valid && frame_active);
  endproperty
  a_drop_cause: assert property (p_drop_cause)
    else $error("ready fell with no byte taken");
  property p_ready_bound;
    $fell(serial_ready_out) |-> ##[1:11] serial_ready_out;
  endproperty
  a_ready_bound: assert property (p_ready_bound)
    else $error("ready low too long");
  property p_rise_answer;
    $rose(serial_ready_out) |-> resp_valid;
  endproperty
  a_rise_answer: assert property (p_rise_answer)
    else $error("ready rose without answer");
  property p_valid_pulse;
    resp_valid |=> !resp_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("answer strobe too long");
  property p_valid_top;
    resp_valid |-> tx_pending && tx_byte == resp_word[63:56];
  endproperty
  a_valid_top: assert property (p_valid_top)
    else $error("first byte is not the top byte");
  property p_idle_zero;
    !tx_pending |-> tx_byte == 8'h00;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("idle byte not zero");
  property p_resp_hold;
    !resp_valid |-> $stable(resp_word);
  endproperty
  a_resp_hold: assert property (p_resp_hold)
    else $error("answer word changed");
  property p_pop_next;
    pop && cur < 4'h7 |=> resp_valid || tx_byte == $past(nxt);
  endproperty
  a_pop_next: assert property (p_pop_next)
    else $error("wrong next byte");
  property p_drain;
    pop && cur == 4'h7 |=> resp_valid || (!tx_pending && tx_byte == 8'h00);
  endproperty
  a_drain: assert property (p_drain)
    else $error("not empty after eight bytes");
endmodule

bind qrr_responder qrr_responder_assertions u_chk (
  .clk(clk), .reset_n(reset_n), .rx_valid(rx_valid), .frame_active(frame_active),
  .tx_take(tx_take), .serial_ready_out(serial_ready_out), .tx_byte(tx_byte),
  .tx_pending(tx_pending), .resp_word(resp_word), .resp_valid(resp_valid)
);

// *** testbench/qrr_host_model.sv ***
// Host controller model driving command frames and draining answers
module qrr_host_model (
  input  wire logic       clk,
  input  wire logic       serial_ready_out,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            frame_active,
  output logic            tx_take
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_data = 8'ha5;
    rx_valid = 1'b0;
    frame_active = 1'b0;
    tx_take = 1'b0;
  end
  // One frame; w collects the bytes shifted back meanwhile
  task automatic xfer(input logic [7:0] b[$], output logic [63:0] w);
    w = 64'h0;
    for (int i = 0; i < 50 && !serial_ready_out; i++) @(negedge clk);
    foreach (b[i]) begin
      @(negedge clk);
      w = {w[55:0], tx_byte};
      rx_data = b[i];
      rx_valid = 1'b1;
      frame_active = 1'b1;
    end
    @(negedge clk);
    rx_valid = 1'b0;
    frame_active = 1'b0;
    // Released line must not keep its last value
    rx_data = ~rx_data;
  endtask
  task automatic take_all(output logic [63:0] w);
    w = 64'h0;
    repeat (8) begin
      @(negedge clk);
      w = {w[55:0], tx_byte};
      tx_take = 1'b1;
    end
    @(negedge clk);
    tx_take = 1'b0;
  endtask
endmodule

// *** testbench/qrr_responder_tb.sv ***
// Self-checking bench for the query responder
module qrr_responder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import qrr_pkg::*;
  logic        clk, reset_n, sys, cwe, uwe;
  logic [55:0] frf, fif, flo;
  logic [7:0]  aif, arf, wd, rx_data, tx_byte;
  logic [31:0] temp, sn, hwr, fwr, mdt, cdt;
  logic [4:0]  lock;
  logic [1:0]  gain;
  logic [13:0] cf;
  logic [3:0]  imap;
  logic [15:0] wa;
  logic [63:0] resp_word;
  logic        rx_valid, frame_active, tx_take, serial_ready_out, tx_pending, resp_valid;
  int          errors = 0;
  int          cmp_count = 0;

  qrr_host_model host (.clk(clk), .serial_ready_out(serial_ready_out), .tx_byte(tx_byte),
    .rx_data(rx_data), .rx_valid(rx_valid), .frame_active(frame_active), .tx_take(tx_take));
  qrr_responder dut (.clk(clk), .reset_n(reset_n), .rx_data(rx_data), .rx_valid(rx_valid),
    .frame_active(frame_active), .tx_take(tx_take), .freq_rf(frf), .freq_if(fif),
    .freq_lo(flo), .atten_if(aif), .atten_rf(arf), .temperature(temp), .loop_lock(lock),
    .loop_gain(gain), .system_accessed(sys), .external_reference_present(cf[0]),
    .external_reference_lock_enabled(cf[1]), .oscillator_power_on(cf[2]),
    .external_oscillator_selected(cf[3]), .oscillator_port_rear(cf[4]),
    .oscillator_direct_entry(cf[5]), .oscillator_doubler_on(cf[6]),
    .standby_asserted(cf[7]), .conversion_bypassed(cf[8]), .intermediate_output_on(cf[9]),
    .spectrum_inverted(cf[10]), .preamplifier_on(cf[11]), .automatic_gain_selected(cf[12]),
    .automatic_amplifier_selected(cf[13]), .serial_number(sn), .interface_map(imap),
    .hw_revision(hwr), .fw_revision(fwr), .mfg_date(mdt), .cal_date(cdt),
    .cal_wr_en(cwe), .user_wr_en(uwe), .nv_wr_addr(wa), .nv_wr_data(wd),
    .serial_ready_out(serial_ready_out), .tx_byte(tx_byte), .tx_pending(tx_pending),
    .resp_word(resp_word), .resp_valid(resp_valid));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Sends a query, checks the answer, then drains it by clock-out or by take
  task automatic query(input string nm, input logic [7:0] b[$], input logic [63:0] e,
                       input bit spi);
    logic [63:0] w;
    int          n;
    host.xfer(b, w);
    n = 0;
    while (!serial_ready_out && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk({nm, " strobe"}, {63'h0, resp_valid}, 64'h1);
    chk(nm, resp_word, e);
    if (spi) host.xfer('{ADDR_CLKOUT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, w);
    else host.take_all(w);
    chk({nm, " drained"}, w, e);
    chk({nm, " empty"}, {55'h0, tx_pending, tx_byte}, 64'h0);
  endtask

  task automatic t_param();
    logic [63:0] e;
    for (int s = 0; s < 4; s++) begin
      case (s)
        0: e = {8'h00, frf};
        1: e = {8'h00, fif};
        2: e = {8'h00, flo};
        default: e = {40'h0, 4'h0, cf[10], cf[9], cf[11], cf[8], arf, aif};
      endcase
      query("param", '{ADDR_PARAM, 8'(s)}, e, s[0]);
    end
  endtask

  task automatic t_cond();
    for (int p = 0; p < 3; p++) begin
      lock = (p == 1) ? 5'h15 : 5'h1e;
      cf = (p == 1) ? 14'h2a58 : 14'h15a7;
      gain = 2'(p);
      sys = p[0];
      query("cond", '{ADDR_COND, 8'h00},
            {41'h0, cf, sys, 1'b0, gain, lock[4] & cf[1], lock[3:0]}, p[0]);
    end
  endtask

  task automatic t_info();
    logic [63:0] e;
    for (int s = 0; s < 4; s++) begin
      case (s)
        0: e = {24'h0, 4'h0, imap, sn};
        1: e = {fwr, hwr};
        2: e = {cdt, mdt};
        default: e = 64'h0;
      endcase
      query("info", '{ADDR_INFO, {4'ha, 4'(s)}}, e, s[0]);
    end
  endtask

  // Writes both stores across the top of the address space to see the wrap
  task automatic t_mem();
    logic [63:0] ec, eu;
    for (int k = 0; k < 16; k++) begin
      wa = 16'hfffc + 16'(k % 8);
      wd = (k < 8) ? (wa[7:0] ^ 8'h5a) : (wa[7:0] + 8'h11);
      cwe = (k < 8);
      uwe = (k >= 8);
      if (k < 8) ec[8*k +: 8] = wd;
      else eu[8*(k-8) +: 8] = wd;
      @(negedge clk);
    end
    cwe = 1'b0;
    uwe = 1'b0;
    query("cal", '{ADDR_CALMEM, 8'h00, 8'hff, 8'hfc}, ec, 1);
    query("user", '{ADDR_USERMEM, 8'h00, 8'hff, 8'hfc}, eu, 0);
  endtask

  task automatic t_abort();
    logic [63:0] w;
    host.xfer('{ADDR_CALMEM, 8'h00}, w);
    host.xfer('{8'h10, ADDR_TEMP, 8'h00}, w);
    repeat (12) begin
      @(negedge clk);
      chk("abort", {62'h0, serial_ready_out, resp_valid}, 64'h2);
    end
    query("temp", '{ADDR_TEMP, 8'h00}, {32'h0, temp}, 1);
  endtask

  initial begin
    reset_n = 1'b0;
    {cwe, uwe, wa, wd} = '0;
    frf = 56'h12_3456_789a_bcde;
    fif = 56'h00_0000_b2d0_5e00;
    flo = 56'h98_7654_3210_fedc;
    {aif, arf, temp, sn} = {8'h2b, 8'h14, 32'h41c8_0000, 32'h0001_e240};
    {hwr, fwr, mdt, cdt} = {32'h3f80_0000, 32'h4000_0000, 32'h07e0_0c1f, 32'h07e1_0305};
    {imap, lock, gain, sys, cf} = {4'hb, 5'h1f, 2'h1, 1'b0, 14'h0a55};
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    chk("reset", {54'h0, serial_ready_out, tx_pending, tx_byte}, 64'h200);
    t_param();
    t_cond();
    t_info();
    t_mem();
    t_abort();
    final_report();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #(40 * 5000);
    errors++;
    $display("ERROR watchdog expected finish seen hang");
    final_report();
  end
endmodule
